// ---- gpib_device.sv ----
// device end of the instrument bus interface
`timescale 1ns/1ps
`include "gpib_regs.svh"
module gpib_device (
   input  wire logic                  clk_sys_in,
   input  wire logic                  rst_in,
   input  wire gpib_pkg::gpib_bus_type bus_in,
   input  wire logic [4:0]            addr_in,
   input  wire logic                  addr_load_in,
   input  wire logic                  local_key_in,
   input  wire logic                  srq_req_in,
   input  wire logic [7:0]            status_in,
   input  wire logic [7:0]            tx_data_in,
   input  wire logic                  tx_eoi_in,
   input  wire logic                  tx_valid_in,
   output logic                       tx_ready_out,
   output logic [7:0]                 rx_data_out,
   output logic                       rx_eoi_out,
   output logic                       rx_valid_out,
   output logic                       rx_ready_out,
   output logic [7:0]                 dio_oe_n_out,
   output logic                       eoi_oe_n_out,
   output logic                       dav_oe_n_out,
   output logic                       nrfd_oe_n_out,
   output logic                       ndac_oe_n_out,
   output logic                       srq_oe_n_out,
   output logic                       talk_out,
   output logic                       listen_out,
   output logic                       remote_out,
   output logic                       lockout_out,
   output logic                       clear_out,
   output logic                       trigger_out,
   output logic [4:0]                 addr_out
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   gpib_pkg::gpib_bus_type sync1;
   gpib_pkg::gpib_bus_type bus;
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         sync1 <= '0;
         bus   <= '0;
      end else begin
         sync1 <= bus_in;
         bus   <= sync1;
      end
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum {AH_IDLE, AH_READY, AH_ACCEPT, AH_WAIT} gpib_ah_type;
   typedef enum {SH_IDLE, SH_SETTLE, SH_WAIT_RFD, SH_DAV, SH_WAIT_DAC} gpib_sh_type;
   gpib_ah_type ah_state;
   gpib_sh_type sh_state;
   logic [4:0]  addr;
   logic        talk, listen, remote, lockout, spoll, srq, srq_sent;
   logic [7:0]  byte_q;
   logic        eoi_q;
   logic        take_byte;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   wire [6:0] cmd      = bus.dio[6:0];
   wire       got      = (ah_state == AH_ACCEPT);
   wire       got_cmd  = got & bus.atn;
   wire       got_data = got & ~bus.atn;
   wire       is_mla   = got_cmd & (cmd[6:5] == `GPIB_GRP_LISTEN) & (cmd[4:0] == addr);
   wire       is_mta   = got_cmd & (cmd[6:5] == `GPIB_GRP_TALK) & (cmd[4:0] == addr);
   wire       is_unl   = got_cmd & (cmd == `GPIB_CMD_UNL);
   wire       is_unt   = got_cmd & (cmd == `GPIB_CMD_UNT);
   wire       is_dcl   = got_cmd & ((cmd == `GPIB_CMD_DCL) | (listen & (cmd == `GPIB_CMD_SDC)));
   wire       is_get   = got_cmd & listen & (cmd == `GPIB_CMD_GET);
   wire       is_gtl   = got_cmd & listen & (cmd == `GPIB_CMD_GTL);
   wire       is_llo   = got_cmd & (cmd == `GPIB_CMD_LLO);
   wire       is_spe   = got_cmd & (cmd == `GPIB_CMD_SPE);
   wire       is_spd   = got_cmd & (cmd == `GPIB_CMD_SPD);
   wire       addr_ok  = addr_load_in & (addr_in <= `GPIB_ADDR_MAX);
   wire       tx_src   = talk & ~bus.atn;
   wire       tx_have  = spoll | tx_valid_in;
   wire [7:0] tx_byte  = spoll ? {status_in[7], srq, status_in[5:0]} : tx_data_in;
   wire       sh_end   = (sh_state == SH_WAIT_DAC) & ~bus.ndac;
   wire       srq_new  = srq_req_in & ~srq_sent;
   wire       next_srq = srq_new | (srq & ~(sh_end & spoll));

   // ----------------------------------------
   // acceptor handshake, holds off data while not listener or rx_valid_out is set
   // ----------------------------------------
   wire accept_ok = bus.atn | (listen & ~rx_valid_out);
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ah_state <= AH_IDLE;
      end else begin
         case (ah_state)
            AH_IDLE:   if (accept_ok & ~tx_src) ah_state <= AH_READY;
            AH_READY:  if (bus.dav) ah_state <= AH_ACCEPT;
                       else if (~accept_ok | tx_src) ah_state <= AH_IDLE;
            AH_ACCEPT: ah_state <= AH_WAIT;
            AH_WAIT:   if (~bus.dav) ah_state <= AH_IDLE;
            default:   ah_state <= AH_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // source handshake
   // ----------------------------------------
   assign take_byte = (sh_state == SH_IDLE) & tx_src & tx_have & ~bus.dav;
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         sh_state <= SH_IDLE;
      end else if (~tx_src | bus.ifc) begin
         sh_state <= SH_IDLE;
      end else begin
         case (sh_state)
            SH_IDLE:     if (take_byte) sh_state <= SH_SETTLE;
            SH_SETTLE:   sh_state <= SH_WAIT_RFD;
            SH_WAIT_RFD: if (~bus.nrfd & ~bus.ndac) sh_state <= SH_WAIT_RFD;
                         else if (~bus.nrfd) sh_state <= SH_DAV;
            SH_DAV:      sh_state <= SH_WAIT_DAC;
            // dav stands until every acceptor has released ndac
            SH_WAIT_DAC: if (~bus.ndac) sh_state <= SH_IDLE;
            default:     sh_state <= SH_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // function states
   // ----------------------------------------
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         addr     <= `GPIB_ADDR_DEFAULT;
         talk     <= 1'b0;
         listen   <= 1'b0;
         remote   <= 1'b0;
         lockout  <= 1'b0;
         spoll    <= 1'b0;
         srq      <= 1'b0;
         srq_sent <= 1'b0;
         byte_q   <= 8'h00;
         eoi_q    <= 1'b0;
      end else begin
         if (addr_ok) addr <= addr_in;
         if (bus.ifc | is_unt | is_mla) talk <= 1'b0;
         else if (is_mta) talk <= 1'b1;
         if (bus.ifc | is_unl | is_mta) listen <= 1'b0;
         else if (is_mla) listen <= 1'b1;
         if (~bus.ren | is_gtl | (local_key_in & ~lockout)) remote <= 1'b0;
         else if (is_mla) remote <= 1'b1;
         if (~bus.ren) lockout <= 1'b0;
         else if (is_llo) lockout <= 1'b1;
         if (bus.ifc | is_spd) spoll <= 1'b0;
         else if (is_spe) spoll <= 1'b1;
         // a fresh request wins over a clear in the same cycle
         srq      <= srq_new | (next_srq & ~is_dcl);
         srq_sent <= srq_req_in & (srq_sent | next_srq);
         if (take_byte) begin
            byte_q <= tx_byte;
            eoi_q  <= tx_eoi_in & ~spoll;
         end
      end
   end

   // ----------------------------------------
   // outputs, open collector with low enable
   // ----------------------------------------
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         dio_oe_n_out  <= 8'hff;
         eoi_oe_n_out  <= 1'b1;
         dav_oe_n_out  <= 1'b1;
         nrfd_oe_n_out <= 1'b1;
         ndac_oe_n_out <= 1'b1;
         srq_oe_n_out  <= 1'b1;
         tx_ready_out  <= 1'b0;
         rx_data_out   <= 8'h00;
         rx_eoi_out    <= 1'b0;
         rx_valid_out  <= 1'b0;
         rx_ready_out  <= 1'b0;
         talk_out      <= 1'b0;
         listen_out    <= 1'b0;
         remote_out    <= 1'b0;
         lockout_out   <= 1'b0;
         clear_out     <= 1'b0;
         trigger_out   <= 1'b0;
         addr_out      <= `GPIB_ADDR_DEFAULT;
      end else begin
         // never drive during identify, no parallel poll response
         dio_oe_n_out  <= (sh_state != SH_IDLE & tx_src) ? ~byte_q : 8'hff;
         eoi_oe_n_out  <= ~((sh_state != SH_IDLE) & tx_src & eoi_q & ~bus.atn);
         dav_oe_n_out  <= ~((sh_state == SH_DAV) | (sh_state == SH_WAIT_DAC)) | ~tx_src;
         nrfd_oe_n_out <= (ah_state == AH_READY) | tx_src;
         ndac_oe_n_out <= (ah_state == AH_WAIT) | tx_src;
         srq_oe_n_out  <= ~srq;
         tx_ready_out  <= take_byte & ~spoll;
         rx_ready_out  <= listen;
         if (got_data & listen) begin
            rx_data_out  <= bus.dio;
            rx_eoi_out   <= bus.eoi;
            rx_valid_out <= 1'b1;
         end else begin
            rx_valid_out <= 1'b0;
         end
         talk_out      <= talk;
         listen_out    <= listen;
         remote_out    <= remote;
         lockout_out   <= lockout;
         clear_out     <= is_dcl;
         trigger_out   <= is_get;
         addr_out      <= addr;
      end
   end
   // ATN, IFC and REN have no driver here at all

   // ----------------------------------------
   // checks
   // ----------------------------------------
   mla_listen_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      is_mla & ~bus.ifc & ~is_mta |=> listen) else $error("listen not set by own address");
   talk_gate_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      ~talk |=> dav_oe_n_out) else $error("drove DAV while not talker");
   untalk_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (is_unt | bus.ifc) |=> ~talk) else $error("talker not idled");
   remote_ren_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $rose(remote) |-> $past(is_mla) & $past(bus.ren)) else $error("remote without MLA and REN");
   dav_seq_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (sh_state == SH_DAV) |-> $past(sh_state == SH_WAIT_RFD) & ~$past(bus.nrfd)) else $error("DAV before ready");
   trig_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      is_get |=> trigger_out ##1 ~trigger_out | is_get) else $error("trigger pulse wrong");
   srq_drop_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      sh_end & spoll & ~srq_new |=> ##1 srq_oe_n_out) else $error("SRQ held after poll");
   clear_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      is_dcl & ~srq_new |=> clear_out & ~srq) else $error("clear not applied");
endmodule : gpib_device

// ---- gpib_regs.svh ----
// constants for the bus device interface
`ifndef GPIB_REGS_SVH
`define GPIB_REGS_SVH
`define GPIB_ADDR_DEFAULT 5'h09
`define GPIB_ADDR_MAX     5'h1e
`define GPIB_CMD_GTL      7'h01
`define GPIB_CMD_SDC      7'h04
`define GPIB_CMD_GET      7'h08
`define GPIB_CMD_LLO      7'h11
`define GPIB_CMD_DCL      7'h14
`define GPIB_CMD_SPE      7'h18
`define GPIB_CMD_SPD      7'h19
`define GPIB_CMD_UNL      7'h3f
`define GPIB_CMD_UNT      7'h5f
`define GPIB_GRP_LISTEN   2'h1
`define GPIB_GRP_TALK     2'h2
`define GPIB_RSV_BIT      6
`endif

// ---- gpib_pkg.sv ----
// types for the bus device interface
package gpib_pkg;
   typedef struct packed {
      logic       atn;
      logic       ifc;
      logic       ren;
      logic       eoi;
      logic       dav;
      logic       nrfd;
      logic       ndac;
      logic [7:0] dio;
   } gpib_bus_type;
endpackage : gpib_pkg

// ---- gpib_ctrl.sv ----
// controller model facing the device bus port
`timescale 1ns/1ps
module gpib_ctrl (
   input  wire logic             clk_in,
   input  wire logic [7:0]       dio_oe_n_in,
   input  wire logic             eoi_oe_n_in,
   input  wire logic             dav_oe_n_in,
   input  wire logic             nrfd_oe_n_in,
   input  wire logic             ndac_oe_n_in,
   output gpib_pkg::gpib_bus_type bus_out
);
   gpib_pkg::gpib_bus_type c     = '0;
   logic                   stuck = 1'b0;
   // released lines read false through the pull-ups
   assign bus_out = {c.atn, c.ifc, c.ren, c.eoi | ~eoi_oe_n_in, c.dav | ~dav_oe_n_in,
                     c.nrfd | ~nrfd_oe_n_in, c.ndac | ~ndac_oe_n_in, c.dio | ~dio_oe_n_in};
   // ack low where the device may refuse the byte
   task automatic send(input logic atn, input logic [7:0] b, input logic ack);
      int n;
      @(posedge clk_in);
      c.atn  <= atn;
      c.nrfd <= 1'b0;
      c.ndac <= 1'b0;
      c.dio  <= b;
      // let every acceptor see atn through its synchroniser
      repeat (6) @(posedge clk_in);
      for (n = 0; n < 300 && bus_out.nrfd; n++) @(posedge clk_in);
      c.dav <= 1'b1;
      @(posedge clk_in);
      for (n = 0; n < 300 && bus_out.ndac; n++) @(posedge clk_in);
      stuck |= ack && n == 300;
      c.dav <= 1'b0;
      @(posedge clk_in);
      c.atn <= 1'b0;
      c.dio <= 8'h00;
   endtask : send
   task automatic recv(output logic [7:0] b, output logic e);
      int n;
      @(posedge clk_in);
      c.ndac <= 1'b1;
      @(posedge clk_in);
      for (n = 0; n < 300 && !bus_out.dav; n++) @(posedge clk_in);
      stuck |= n == 300;
      b = bus_out.dio;
      e = bus_out.eoi;
      c.nrfd <= 1'b1;
      c.ndac <= 1'b0;
      for (n = 0; n < 300 && bus_out.dav; n++) @(posedge clk_in);
      stuck |= n == 300;
      c.nrfd <= 1'b0;
   endtask : recv
endmodule : gpib_ctrl

// ---- tb.sv ----
// self-checking bench for the device bus port
`timescale 1ns/1ps
`include "gpib_regs.svh"
module tb;
   localparam logic [7:0] mla = {1'b0, `GPIB_GRP_LISTEN, `GPIB_ADDR_DEFAULT};
   localparam logic [7:0] mta = {1'b0, `GPIB_GRP_TALK, `GPIB_ADDR_DEFAULT};
   logic clk_sys_in = 1'b0, rst_in = 1'b1, addr_load_in = 1'b0, local_key_in = 1'b0, srq_req_in = 1'b0;
   logic tx_eoi_in = 1'b0, tx_valid_in = 1'b0, tx_ready_out, rx_valid_out, talk_out, listen_out;
   logic remote_out, clear_out, trigger_out, srq_oe_n_out, dav_oe_n_out, eoi_oe_n_out, nrfd_oe_n_out;
   logic ndac_oe_n_out, e, rx_eoi_out, rx_ready_out, lockout_out, rx_eoi_last = 1'b0;
   logic [4:0] addr_in = 5'h00, addr_out;
   logic [7:0] status_in = 8'h00, tx_data_in = 8'h00, rx_data_out, dio_oe_n_out, rx_last = 8'h00, b;
   gpib_pkg::gpib_bus_type bus;
   int rx_n = 0, trg_n = 0, clr_n = 0, mismatches = 0, num_checks = 0;
   gpib_device i_gpib_device (.clk_sys_in, .rst_in, .bus_in(bus), .addr_in, .addr_load_in, .local_key_in,
      .srq_req_in, .status_in, .tx_data_in, .tx_eoi_in, .tx_valid_in, .tx_ready_out, .rx_data_out,
      .rx_eoi_out, .rx_valid_out, .rx_ready_out, .dio_oe_n_out, .eoi_oe_n_out, .dav_oe_n_out,
      .nrfd_oe_n_out, .ndac_oe_n_out, .srq_oe_n_out, .talk_out, .listen_out, .remote_out,
      .lockout_out, .clear_out, .trigger_out, .addr_out);
   gpib_ctrl i_gpib_ctrl (.clk_in(clk_sys_in), .dio_oe_n_in(dio_oe_n_out), .eoi_oe_n_in(eoi_oe_n_out),
      .dav_oe_n_in(dav_oe_n_out), .nrfd_oe_n_in(nrfd_oe_n_out), .ndac_oe_n_in(ndac_oe_n_out), .bus_out(bus));
   always #5 clk_sys_in = ~clk_sys_in;
   // pulse counters, and the talk byte drops once taken
   always @(posedge clk_sys_in) begin
      rx_n  <= rx_n + int'(rx_valid_out === 1'b1);
      trg_n <= trg_n + int'(trigger_out === 1'b1);
      clr_n <= clr_n + int'(clear_out === 1'b1);
      if (rx_valid_out === 1'b1) begin
         rx_last     <= rx_data_out;
         rx_eoi_last <= rx_eoi_out;
      end
      if (tx_ready_out === 1'b1) tx_valid_in <= 1'b0;
   end
   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask : chk
   task automatic cmd(input logic [7:0] c);
      i_gpib_ctrl.send(1'b1, c, 1'b1);
      repeat (6) @(posedge clk_sys_in);
   endtask : cmd
   task automatic ld(input logic [4:0] a);
      @(posedge clk_sys_in);
      addr_in      <= a;
      addr_load_in <= 1'b1;
      @(posedge clk_sys_in);
      addr_load_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
   endtask : ld
   // ----
   // scenarios
   // ----
   task automatic t_listen;
      chk(addr_out === 5'h09 && srq_oe_n_out === 1'b1 && rx_ready_out === 1'b0, "reset state");
      i_gpib_ctrl.send(1'b0, 8'h41, 1'b0);
      repeat (6) @(posedge clk_sys_in);
      chk(rx_n === 0, "unaddressed rx");
      i_gpib_ctrl.c.ren <= 1'b1;
      cmd(mla);
      chk(listen_out === 1'b1 && remote_out === 1'b1, "no remote");
      i_gpib_ctrl.c.eoi <= 1'b1;
      i_gpib_ctrl.send(1'b0, 8'h5a, 1'b1);
      i_gpib_ctrl.c.eoi <= 1'b0;
      repeat (6) @(posedge clk_sys_in);
      chk(rx_n === 1 && rx_last === 8'h5a && rx_eoi_last === 1'b1, "rx byte");
      chk(rx_ready_out === 1'b1, "rx not ready");
      cmd({1'b0, `GPIB_CMD_GET});
      chk(trg_n === 1, "no trigger");
      cmd({1'b0, `GPIB_CMD_LLO});
      local_key_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      local_key_in <= 1'b0;
      chk(remote_out === 1'b1, "lockout");
      chk(lockout_out === 1'b1, "no lockout flag");
      cmd({1'b0, `GPIB_CMD_GTL});
      chk(remote_out === 1'b0, "still remote");
      i_gpib_ctrl.c.atn <= 1'b1;
      i_gpib_ctrl.c.eoi <= 1'b1;
      repeat (8) @(posedge clk_sys_in);
      chk(dio_oe_n_out === 8'hff, "poll answer");
      i_gpib_ctrl.c.eoi <= 1'b0;
      cmd(mta);
      chk(listen_out === 1'b0 && talk_out === 1'b1, "still listener");
      cmd({1'b0, `GPIB_CMD_UNT});
      $display("listen done");
   endtask : t_listen
   task automatic t_talk;
      tx_data_in  <= 8'ha5;
      tx_eoi_in   <= 1'b1;
      tx_valid_in <= 1'b1;
      repeat (20) @(posedge clk_sys_in);
      chk(dav_oe_n_out === 1'b1, "untalked tx");
      cmd(mta);
      i_gpib_ctrl.recv(b, e);
      chk(b === 8'ha5 && e === 1'b1, "tx byte");
      cmd(mla);
      chk(talk_out === 1'b0, "talk on mla");
      cmd(mta);
      cmd({1'b0, `GPIB_CMD_UNT});
      chk(talk_out === 1'b0, "talk on unt");
      cmd(mta);
      i_gpib_ctrl.c.ifc <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      i_gpib_ctrl.c.ifc <= 1'b0;
      repeat (6) @(posedge clk_sys_in);
      chk(talk_out === 1'b0, "talk on ifc");
      $display("talk done");
   endtask : t_talk
   task automatic t_misc;
      cmd({1'b0, `GPIB_CMD_DCL});
      cmd(mla);
      cmd({1'b0, `GPIB_CMD_SDC});
      chk(clr_n === 2, "clear count");
      cmd({1'b0, `GPIB_CMD_UNL});
      cmd(8'h69);
      chk(listen_out === 1'b0 && talk_out === 1'b0, "secondary address");
      ld(5'h1e);
      chk(addr_out === 5'h1e, "addr 30");
      ld(5'h1f);
      chk(addr_out === 5'h1e, "addr 31");
      ld(5'h09);
      srq_req_in <= 1'b1;
      status_in  <= 8'h05;
      repeat (8) @(posedge clk_sys_in);
      chk(srq_oe_n_out === 1'b0, "no srq");
      cmd({1'b0, `GPIB_CMD_SPE});
      cmd(mta);
      i_gpib_ctrl.recv(b, e);
      repeat (6) @(posedge clk_sys_in);
      chk(b === 8'h45 && srq_oe_n_out === 1'b1, "poll byte");
      cmd({1'b0, `GPIB_CMD_SPD});
      cmd({1'b0, `GPIB_CMD_UNT});
      $display("misc done");
   endtask : t_misc
   task automatic conclude;
      if (i_gpib_ctrl.stuck !== 1'b0) mismatches++;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   initial begin
      repeat (5) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      t_listen();
      t_talk();
      t_misc();
      conclude();
   end
   initial begin
      repeat (30000) @(posedge clk_sys_in);
      mismatches++;
      conclude();
   end
endmodule : tb
